// *** core/program_memory_bank_extension.sv ***
// Summary of operation
// R1: three bank bits above the 16-bit counter give eight 64 Kbyte banks, 512 Kbytes.
// R2: reset clears current and next bank, so execution starts at address zero.
// R3: software writes next bank; current bank is read only.
// R4: a long jump, like a call, copies next bank into current bank.
// R5: table read drives current bank, or table bank when mode select is one.
// R6: calls push both banks on a 32-deep stack, then next becomes current.
// R7: returns pop the stack and restore both next and current bank.
// R8: interrupt entry pushes both banks, then loads both from the isr bank.
// R9: reset clears table mode select, table bank and isr bank.
// R10: stack full warning is set when stack overflow is imminent.
// R11: software wanting 128 Kbytes sets banks to ones and long jumps.
// R12: each fourth port pin is current bank bit AND its port latch.
// R13: reset sets port latches to one, so the pins drive zero.
// R14: interrupt entry addresses 03,0B,13,1B,23,2B,33 hex by source.
// R15: all six bank bits are saved on each stack level.
// R16: stack full is high at level 31, cleared when a return drops below.
// R17: fetches use current bank, unchanged by a next bank write alone.
//
// Local design decisions: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "bank_ext_defines.svh"
module program_memory_bank_extension #(
  parameter int DEPTH = 32
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire bank_ext_pkg::cpu_event_type cpu_event,
  input wire bank_ext_pkg::irq_source_type irq_source,
  output logic [7:0] irq_vector,
  output logic [2:0] upper_addr,
  output logic [1:0] fourth_port,
  output logic irq
);
  localparam int PW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad_depth
    $error("DEPTH must be a power of two");
  end
  bank_ext_pkg::bank_pair_type bank_state_register;
  bank_ext_pkg::bank_pair_type stack_mem [DEPTH];
  logic [2:0] isr_bank;
  logic [2:0] table_read_bank;
  logic table_read_mode_select;
  logic ext_stack_full;
  logic [PW-1:0] sp;
  logic [1:0] port_latch;
  logic [1:0] irq_status;
  logic [1:0] irq_mask;
  logic ack;
  logic do_write;
  logic do_read;
  logic push;
  logic pop;
  logic [1:0] event_set;
  bank_ext_pkg::bank_pair_type popped;

  // one wait cycle per access keeps read data registered
  // writes land only at the edge where waitrequest is seen low
  assign do_write = avs_write && ack;
  assign do_read = avs_read && !ack;
  assign avs_waitrequest = (avs_read || avs_write) && !ack;
  assign push = cpu_event.call || cpu_event.irq_entry;
  // a return on an empty stack is only flagged, so no unwritten entry is restored
  assign pop = cpu_event.ret && !push && sp != '0;
  assign popped = stack_mem[sp - PW'(1)];

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ack <= 1'b0;
    end else begin
      ack <= (avs_read || avs_write) && !ack;
    end
  end

  // interrupt entry, call, a return on a non-empty stack and long jump outrank a same-cycle software write of next bank; a table read does not
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      bank_state_register <= '{`BANK_RESET, `BANK_RESET}; // [R2]
    end else if (cpu_event.irq_entry) begin
      bank_state_register <= '{isr_bank, isr_bank}; // [R8]
    end else if (cpu_event.call) begin
      bank_state_register.current_bank <= bank_state_register.next_bank; // [R6]
    end else if (pop) begin
      bank_state_register <= popped; // [R7]
    end else if (cpu_event.long_jump) begin
      bank_state_register.current_bank <= bank_state_register.next_bank; // [R4] [R11]
    end else if (do_write && avs_address == `STATE_OFFSET) begin
      bank_state_register.next_bank <= avs_writedata[5:3]; // [R3] [R17]
    end
  end

  always_ff @(posedge sys_clk) begin
    if (push) begin
      stack_mem[sp] <= bank_state_register; // [R15]
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sp <= '0;
    end else if (push) begin
      sp <= sp + PW'(1); // [R6]
    end else if (pop) begin
      sp <= sp - PW'(1); // [R7]
    end
  end

  // flag tracks the pointer so a pop below the top clears it
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ext_stack_full <= 1'b0;
    end else if (push) begin
      ext_stack_full <= (sp + PW'(1)) == PW'(DEPTH - 1); // [R10] [R16]
    end else if (pop) begin
      ext_stack_full <= 1'b0; // [R16]
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      isr_bank <= `BANK_RESET; // [R9]
      table_read_bank <= `BANK_RESET;
      table_read_mode_select <= 1'b0;
    end else if (do_write && avs_address == `OPTION_OFFSET) begin
      isr_bank <= avs_writedata[2:0];
      table_read_mode_select <= avs_writedata[`OPT_MM_BIT];
      table_read_bank <= avs_writedata[6:4];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      port_latch <= `LATCH_RESET; // [R13]
    end else if (do_write && avs_address == `PORT_LATCH_OFFSET) begin
      port_latch <= avs_writedata[1:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_mask <= 2'h0;
    end else if (do_write && avs_address == `IRQ_MASK_OFFSET) begin
      irq_mask <= avs_writedata[1:0];
    end
  end

  // bit0 stack became full, bit1 bank stack popped while empty
  assign event_set = {cpu_event.ret && !push && sp == '0,
                      push && (sp + PW'(1)) == PW'(DEPTH - 1)};

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_status <= 2'h0;
    end else if (do_read && avs_address == `IRQ_STATUS_OFFSET) begin
      irq_status <= event_set;
    end else begin
      irq_status <= irq_status | event_set;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      avs_readdata <= 32'h0;
    end else if (do_read) begin
      if (avs_address == `STATE_OFFSET) begin
        avs_readdata <= {26'h0, bank_state_register};
      end else if (avs_address == `OPTION_OFFSET) begin
        avs_readdata <= {24'h0, ext_stack_full, table_read_bank, table_read_mode_select, isr_bank};
      end else if (avs_address == `IRQ_STATUS_OFFSET) begin
        avs_readdata <= {30'h0, irq_status};
      end else if (avs_address == `IRQ_MASK_OFFSET) begin
        avs_readdata <= {30'h0, irq_mask};
      end else if (avs_address == `PORT_LATCH_OFFSET) begin
        avs_readdata <= {30'h0, port_latch};
      end else begin
        avs_readdata <= 32'h0;
      end
    end
  end

  // table reads may use an independent bank; fetches always use current
  always_comb begin
    if (cpu_event.table_read && table_read_mode_select) begin
      upper_addr = table_read_bank; // [R5]
    end else begin
      upper_addr = bank_state_register.current_bank; // [R1] [R5] [R17]
    end
  end

  assign fourth_port = bank_state_register.current_bank[2:1] & port_latch; // [R12]

  always_comb begin
    case (irq_source)
      bank_ext_pkg::src_ext0: irq_vector = `VEC_EXT0; // [R14]
      bank_ext_pkg::src_timer0: irq_vector = `VEC_TIMER0;
      bank_ext_pkg::src_ext1: irq_vector = `VEC_EXT1;
      bank_ext_pkg::src_timer1: irq_vector = `VEC_TIMER1;
      bank_ext_pkg::src_serial: irq_vector = `VEC_SERIAL;
      bank_ext_pkg::src_sync: irq_vector = `VEC_SYNC;
      bank_ext_pkg::src_adc: irq_vector = `VEC_ADC;
      default: irq_vector = `VEC_EXT0;
    endcase
  end

  a_long_jump_copy: assert property (@(posedge sys_clk) disable iff (!rst_b)
    cpu_event == 5'b10000 |=> bank_state_register.current_bank ==
    $past(bank_state_register.next_bank)) else $error("long jump did not copy bank"); // [R4]
  a_write_keeps_current: assert property (@(posedge sys_clk) disable iff (!rst_b)
    cpu_event == 5'b00000 |=> $stable(bank_state_register.current_bank))
    else $error("current bank moved without jump"); // [R17]
  a_irq_loads_isr: assert property (@(posedge sys_clk) disable iff (!rst_b)
    cpu_event.irq_entry |=> bank_state_register == {2{$past(isr_bank)}})
    else $error("isr bank not loaded"); // [R8]
  a_call_pushes: assert property (@(posedge sys_clk) disable iff (!rst_b)
    cpu_event.call && !cpu_event.irq_entry |=> sp == $past(sp) + PW'(1) &&
    bank_state_register.current_bank == $past(bank_state_register.next_bank))
    else $error("call push wrong"); // [R6]
  a_call_return_pair: assert property (@(posedge sys_clk) disable iff (!rst_b)
    cpu_event == 5'b01000 ##1 cpu_event == 5'b00100 |=>
    bank_state_register == $past(bank_state_register, 2))
    else $error("return did not restore banks"); // [R7] [R15]
  a_full_flag: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ext_stack_full == (sp == PW'(DEPTH - 1))) else $error("stack full flag wrong"); // [R16] [R10]
  a_table_bank: assert property (@(posedge sys_clk) disable iff (!rst_b)
    cpu_event.table_read && table_read_mode_select |-> upper_addr == table_read_bank)
    else $error("table read bank wrong"); // [R5]
  a_port_and: assert property (@(posedge sys_clk) disable iff (!rst_b)
    fourth_port[1] == (bank_state_register.current_bank[2] && port_latch[1]))
    else $error("fourth port not and of bank and latch"); // [R12]
  a_irq_level: assert property (@(posedge sys_clk) disable iff (!rst_b)
    |(irq_status & irq_mask) |=> irq) else $error("interrupt not raised"); // [R10]

  a_ret_pops: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R7]
    pop |=> sp == $past(sp) - PW'(1))
    else $error("return did not lower pointer");

  a_ret_restores: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R7]
    pop |=> bank_state_register == $past(popped))
    else $error("return did not restore entry");

  a_push_stores: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R15]
    push |=> stack_mem[$past(sp)] == $past(bank_state_register))
    else $error("push did not save six bits");

  a_irq_pushes: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R8]
    cpu_event.irq_entry |=> sp == $past(sp) + PW'(1))
    else $error("interrupt entry did not push");

  a_underflow_holds: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R7]
    cpu_event.ret && !push && sp == '0 |=> sp == '0)
    else $error("empty stack pointer moved");

  a_jump_keeps_next: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R4]
    cpu_event == 5'b10000 |=> bank_state_register.next_bank ==
    $past(bank_state_register.next_bank)) else $error("long jump changed next bank");

  a_call_keeps_next: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R6]
    cpu_event == 5'b01000 |=> bank_state_register.next_bank ==
    $past(bank_state_register.next_bank)) else $error("call changed next bank");

  a_fetch_bank: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R17]
    !cpu_event.table_read |-> upper_addr == bank_state_register.current_bank)
    else $error("fetch not from current bank");

  a_table_current: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R5]
    cpu_event.table_read && !table_read_mode_select |->
    upper_addr == bank_state_register.current_bank) else $error("table read not current");

  a_port_low_bit: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R12]
    fourth_port[0] == (bank_state_register.current_bank[1] && port_latch[0]))
    else $error("fourth port low bit wrong");

  a_vector_ext0: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R14]
    irq_source == bank_ext_pkg::src_ext0 |-> irq_vector == `VEC_EXT0)
    else $error("vector wrong for source 0");

  a_vector_timer0: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R14]
    irq_source == bank_ext_pkg::src_timer0 |-> irq_vector == `VEC_TIMER0)
    else $error("vector wrong for source 1");

  a_vector_ext1: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R14]
    irq_source == bank_ext_pkg::src_ext1 |-> irq_vector == `VEC_EXT1)
    else $error("vector wrong for source 2");

  a_vector_timer1: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R14]
    irq_source == bank_ext_pkg::src_timer1 |-> irq_vector == `VEC_TIMER1)
    else $error("vector wrong for source 3");

  a_vector_serial: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R14]
    irq_source == bank_ext_pkg::src_serial |-> irq_vector == `VEC_SERIAL)
    else $error("vector wrong for source 4");

  a_vector_sync: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R14]
    irq_source == bank_ext_pkg::src_sync |-> irq_vector == `VEC_SYNC)
    else $error("vector wrong for source 5");

  a_vector_adc: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R14]
    irq_source == bank_ext_pkg::src_adc |-> irq_vector == `VEC_ADC)
    else $error("vector wrong for source 6");

  a_full_clears: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R16]
    pop |=> !ext_stack_full)
    else $error("stack full not cleared by return");

  a_full_sets: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R10]
    push && sp == PW'(DEPTH - 2) |=> ext_stack_full)
    else $error("stack full not set at top level");

  a_status_sticky: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R10]
    irq_status[0] && !(do_read && avs_address == `IRQ_STATUS_OFFSET) |=> irq_status[0])
    else $error("status bit lost without read");

  a_irq_low: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R10]
    !(|(irq_status & irq_mask)) |=> !irq)
    else $error("interrupt high with nothing pending");

  a_write_lands: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R3]
    avs_write && !avs_waitrequest && avs_address == `STATE_OFFSET && cpu_event == 5'b00000
    |=> bank_state_register.next_bank == $past(avs_writedata[5:3]))
    else $error("next bank write lost");

  a_current_ro: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R3]
    avs_write && avs_address == `STATE_OFFSET && cpu_event == 5'b00000 |=>
    bank_state_register.current_bank == $past(bank_state_register.current_bank))
    else $error("current bank written by software");

  a_option_lands: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R5]
    avs_write && !avs_waitrequest && avs_address == `OPTION_OFFSET |=>
    table_read_bank == $past(avs_writedata[6:4]) &&
    table_read_mode_select == $past(avs_writedata[`OPT_MM_BIT])) else $error("option write lost");

  a_wait_one: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R3]
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("more than one wait cycle");
endmodule : program_memory_bank_extension
`default_nettype wire

// *** core/bank_ext_defines.svh ***
`ifndef BANK_EXT_DEFINES_SVH
`define BANK_EXT_DEFINES_SVH
`define STATE_OFFSET 5'h00
`define OPTION_OFFSET 5'h04
`define IRQ_STATUS_OFFSET 5'h08
`define IRQ_MASK_OFFSET 5'h0C
`define PORT_LATCH_OFFSET 5'h10
`define BANK_RESET 3'h0
`define LATCH_RESET 2'h3
`define OPT_MM_BIT 3
`define OPT_SF_BIT 7
`define VEC_EXT0 8'h03
`define VEC_TIMER0 8'h0B
`define VEC_EXT1 8'h13
`define VEC_TIMER1 8'h1B
`define VEC_SERIAL 8'h23
`define VEC_SYNC 8'h2B
`define VEC_ADC 8'h33
`endif

// *** core/bank_ext_pkg.sv ***
package bank_ext_pkg;
  typedef struct packed {
    logic [2:0] next_bank;
    logic [2:0] current_bank;
  } bank_pair_type;
  typedef struct packed {
    logic long_jump;
    logic call;
    logic ret;
    logic irq_entry;
    logic table_read;
  } cpu_event_type;
  typedef enum logic [2:0] {
    src_ext0, src_timer0, src_ext1, src_timer1, src_serial, src_sync, src_adc
  } irq_source_type;
endpackage : bank_ext_pkg

// *** tb/ext_prog_mem.sv ***
`timescale 1ns/1ps
`default_nettype none
module ext_prog_mem (
  input wire logic [2:0] upper_addr,
  output logic [7:0] fetch_data
);
  // each byte carries its bank number so the bench sees which bank answered
  assign fetch_data = {5'h15, upper_addr};
endmodule : ext_prog_mem
`default_nettype wire

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic sys_clk, rst_b, avs_read, avs_write, avs_waitrequest, irq;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [7:0] irq_vector, fetch_data;
  logic [2:0] upper_addr;
  logic [1:0] fourth_port;
  bank_ext_pkg::cpu_event_type cpu_event;
  bank_ext_pkg::irq_source_type irq_source;
  int num_errors = 0;
  int compares = 0;
  logic [7:0] vec [7] = '{8'h03, 8'h0B, 8'h13, 8'h1B, 8'h23, 8'h2B, 8'h33};
  program_memory_bank_extension #(.DEPTH(32)) program_memory_bank_extension_inst (
    .sys_clk(sys_clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .cpu_event(cpu_event), .irq_source(irq_source),
    .irq_vector(irq_vector), .upper_addr(upper_addr), .fourth_port(fourth_port), .irq(irq)
  );
  ext_prog_mem ext_prog_mem_inst (.upper_addr(upper_addr), .fetch_data(fetch_data));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task close_out;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : close_out
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // holds the request until waitrequest is seen low at a rising edge
  task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    rd = avs_readdata;
    if (n >= 20) num_errors++;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge sys_clk);
  endtask : bus
  task rdc(input logic [4:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdc
  task ev(input logic [4:0] e);
    cpu_event <= e;
    @(posedge sys_clk);
    cpu_event <= 5'h00;
    @(posedge sys_clk);
  endtask : ev
  task s_reset;
    chk(32'(upper_addr), 32'h0);
    chk(32'(fourth_port), 32'h0);
    rdc(5'h00, 32'h0);
    rdc(5'h04, 32'h0);
    rdc(5'h10, 32'h3);
    rdc(5'h14, 32'h0);
  endtask : s_reset
  task s_jump;
    bus(1'b1, 5'h00, 32'h2F);
    rdc(5'h00, 32'h28);
    chk(32'(upper_addr), 32'h0);
    ev(5'h10);
    chk(32'(upper_addr), 32'h5);
    chk(32'(fetch_data), 32'hAD);
    chk(32'(fourth_port), 32'h2);
    bus(1'b1, 5'h10, 32'h1);
    chk(32'(fourth_port), 32'h0);
    bus(1'b1, 5'h10, 32'h3);
  endtask : s_jump
  task s_table;
    bus(1'b1, 5'h04, 32'h6A);
    cpu_event <= 5'h01;
    @(posedge sys_clk);
    @(posedge sys_clk);
    chk(32'(upper_addr), 32'h6);
    bus(1'b1, 5'h04, 32'h62);
    chk(32'(upper_addr), 32'h5);
    cpu_event <= 5'h00;
    @(posedge sys_clk);
  endtask : s_table
  task s_call_irq;
    bus(1'b1, 5'h00, 32'h18);
    ev(5'h08);
    rdc(5'h00, 32'h1B);
    ev(5'h04);
    rdc(5'h00, 32'h1D);
    for (int i = 0; i < 7; i++) begin
      irq_source <= bank_ext_pkg::irq_source_type'(i);
      @(posedge sys_clk);
      @(posedge sys_clk);
      chk(32'(irq_vector), 32'(vec[i]));
    end
    bus(1'b1, 5'h00, 32'h38);
    ev(5'h02);
    rdc(5'h00, 32'h12);
    ev(5'h04);
    rdc(5'h00, 32'h3D);
  endtask : s_call_irq
  task s_full;
    bus(1'b1, 5'h0C, 32'h1);
    repeat (30) ev(5'h08);
    rdc(5'h04, 32'h62);
    ev(5'h08);
    rdc(5'h04, 32'hE2);
    chk(32'(irq), 32'h1);
    rdc(5'h08, 32'h1);
    @(posedge sys_clk);
    chk(32'(irq), 32'h0);
    ev(5'h04);
    rdc(5'h04, 32'h62);
    repeat (31) ev(5'h04);
    rdc(5'h08, 32'h2);
    chk(32'(irq), 32'h0);
  endtask : s_full
  task s_narrow;
    bus(1'b1, 5'h04, 32'h77);
    bus(1'b1, 5'h00, 32'h38);
    ev(5'h10);
    rdc(5'h00, 32'h3F);
    chk(32'(fourth_port), 32'h3);
    bus(1'b1, 5'h10, 32'h2);
    chk(32'(fourth_port), 32'h2);
    bus(1'b1, 5'h10, 32'h3);
  endtask : s_narrow
  initial begin
    repeat (5000) @(posedge sys_clk);
    num_errors++;
    close_out();
  end
  initial begin
    rst_b = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 5'h00;
    avs_writedata = 32'h0;
    cpu_event = 5'h00;
    irq_source = bank_ext_pkg::src_ext0;
    repeat (6) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    s_reset();
    s_jump();
    s_table();
    s_call_irq();
    s_full();
    s_narrow();
    close_out();
  end
endmodule : tb_top
`default_nettype wire
